/* include/timer_pair_consts.svh */
// Offsets, pages, field positions and timing counts for the timer pair.
`ifndef TIMER_PAIR_CONSTS_SVH
`define TIMER_PAIR_CONSTS_SVH
`define TP_ADDR_CONTROL 8'hC8
`define TP_ADDR_RELOAD_LOW 8'hCA
`define TP_ADDR_RELOAD_HIGH 8'hCB
`define TP_ADDR_COUNT_LOW 8'hCC
`define TP_ADDR_COUNT_HIGH 8'hCD
`define TP_PAGE_TIMER_A 4'h3
`define TP_PAGE_TIMER_B 4'h4
`define TP_BIT_FLAG 7
`define TP_BIT_RESERVED 6
`define TP_BITS_CLOCK_SEL 5:4
`define TP_BIT_IRQ_ENABLE 3
`define TP_BIT_RUN 2
`define TP_BITS_GATE_SEL 1:0
`define TP_CONTROL_RESET 8'h00
`define TP_BYTE_RESET 8'h00
`define TP_COUNT_RESET 16'h0000
`define TP_COUNT_MAX 16'hFFFF
`define TP_DIV12_LAST 4'hB
`define TP_DIV12_RESET 4'h0
`define TP_SYNC_WIDTH 7
`define TP_IN_PIN_A 0
`define TP_IN_PIN_B 1
`define TP_IN_IRQ0 2
`define TP_IN_IRQ1 3
`define TP_IN_IRQ2 4
`define TP_IN_EXI2 5
`define TP_IN_EXI3 6
`endif

/* include/timer_pair_pkg.sv */
// Types shared by the timer pair: clock and gate selector encodings.
`default_nettype none
package timer_pair_pkg;
  typedef enum logic [1:0] {
    CLK_DIV12 = 2'b00,
    CLK_PIN = 2'b01,
    CLK_SYSTEM = 2'b10,
    CLK_EXT_SEL = 2'b11
  } clock_sel_e;
  typedef enum logic [1:0] {
    GATE_NONE = 2'b00,
    GATE_IRQ_LOW = 2'b01,
    GATE_IRQ2_LOW = 2'b10,
    GATE_EXT_SEL = 2'b11
  } gate_sel_e;
endpackage : timer_pair_pkg
`default_nettype wire

/* logic/timer_count_unit.sv */
// One 16-bit auto-reload counter with byte-wide count and reload registers.
`include "timer_pair_consts.svh"
`default_nettype none
module timer_count_unit
  import timer_pair_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic count_tick,
  input wire logic dma_enable,
  input wire logic dma_step,
  input wire logic dma_reload,
  input wire logic wr_count_low,
  input wire logic wr_count_high,
  input wire logic wr_reload_low,
  input wire logic wr_reload_high,
  input wire logic [7:0] wdata,
  output logic [15:0] count,
  output logic [15:0] reload,
  output logic overflow
);
  logic [15:0] next_count;
  logic [15:0] next_reload;
  logic next_overflow;
  logic advance;

  // Timer ticks count only with DMA off; DMA steps count only with DMA on.
  always_comb begin
    advance = dma_enable ? dma_step : count_tick;
    next_count = count;
    next_reload = reload;
    next_overflow = 1'b0;
    if (advance) begin
      if (count == `TP_COUNT_MAX) begin
        next_count = reload;
        next_overflow = 1'b1;
      end else begin
        next_count = count + 16'h0001;
      end
    end
    // A loop restart from the DMA engine brings back the base value.
    if (dma_enable && dma_reload) begin
      next_count = reload;
    end
    // Software writes win over a tick in the same cycle, so the written
    // byte is never half overwritten by a carry.
    if (wr_count_low) begin
      next_count[7:0] = wdata;
    end
    if (wr_count_high) begin
      next_count[15:8] = wdata;
    end
    if (wr_reload_low) begin
      next_reload[7:0] = wdata;
    end
    if (wr_reload_high) begin
      next_reload[15:8] = wdata;
    end
  end

  // Register stage; everything clears to zero.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count <= `TP_COUNT_RESET;
      reload <= `TP_COUNT_RESET;
      overflow <= 1'b0;
    end else begin
      count <= next_count;
      reload <= next_reload;
      overflow <= next_overflow;
    end
  end

  a_reload_on_wrap: assert property (
    @(posedge clk_sys) disable iff (srst)
    (advance && count == `TP_COUNT_MAX && !dma_reload && !wr_count_low
     && !wr_count_high) |=> (count == $past(reload) && overflow))
    else $error("Counter did not reload after wrapping.");
endmodule : timer_count_unit
`default_nettype wire

/* logic/dma_companion_timer_pair.sv */
// Two byte-programmed timer/counters that also hold DMA count and address.
`include "timer_pair_consts.svh"
`default_nettype none
module dma_companion_timer_pair
  import timer_pair_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic timer_a_pin,
  input wire logic timer_b_pin,
  input wire logic ext_irq0_event,
  input wire logic ext_irq1_event,
  input wire logic ext_irq2_event,
  input wire logic timer2_ext_input_sel,
  input wire logic timer3_ext_input_sel,
  input wire logic dma_enable,
  input wire logic dma_step_count,
  input wire logic dma_step_address,
  input wire logic dma_reload,
  output logic [15:0] transfer_count,
  output logic [15:0] memory_address,
  output logic dma_irq
);
  logic [`TP_SYNC_WIDTH-1:0] raw_in;
  logic [`TP_SYNC_WIDTH-1:0] sync_first;
  logic [`TP_SYNC_WIDTH-1:0] sync_level;
  logic [`TP_SYNC_WIDTH-1:0] sync_prev;
  logic [`TP_SYNC_WIDTH-1:0] falling;
  logic [3:0] div_count;
  logic [3:0] next_div_count;
  logic div_tick;
  logic next_div_tick;
  logic [7:0] timer_a_control;
  logic [7:0] timer_b_control;
  logic [7:0] control [2];
  logic [7:0] next_control [2];
  logic [15:0] count [2];
  logic [15:0] reload [2];
  logic [1:0] overflow;
  logic [1:0] count_tick;
  logic [1:0] page_hit;
  logic [1:0] dma_step;
  logic [7:0] next_rdata;
  logic next_irq;

  assign raw_in = {timer3_ext_input_sel, timer2_ext_input_sel,
                   ext_irq2_event, ext_irq1_event, ext_irq0_event,
                   timer_b_pin, timer_a_pin};
  assign dma_step = {dma_step_address, dma_step_count};
  assign timer_a_control = control[0];
  assign timer_b_control = control[1];
  assign page_hit[0] = (sfr_page == `TP_PAGE_TIMER_A);
  assign page_hit[1] = (sfr_page == `TP_PAGE_TIMER_B);

  // Two-stage synchronisers plus one history stage for edge detection.
  // Only the second stage and later are looked at by any logic.
  genvar gi;
  generate
    for (gi = 0; gi < `TP_SYNC_WIDTH; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          sync_first[gi] <= 1'b0;
          sync_level[gi] <= 1'b0;
          sync_prev[gi] <= 1'b0;
        end else begin
          sync_first[gi] <= raw_in[gi];
          sync_level[gi] <= sync_first[gi];
          sync_prev[gi] <= sync_level[gi];
        end
      end
      assign falling[gi] = sync_prev[gi] & ~sync_level[gi];
    end
  endgenerate

  // Shared divide-by-12 prescaler; one pulse every twelve system clocks.
  always_comb begin
    next_div_count = div_count + 4'h1;
    next_div_tick = 1'b0;
    if (div_count == `TP_DIV12_LAST) begin
      next_div_count = `TP_DIV12_RESET;
      next_div_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_count <= `TP_DIV12_RESET;
      div_tick <= 1'b0;
    end else begin
      div_count <= next_div_count;
      div_tick <= next_div_tick;
    end
  end

  // Per-timer clock selection, gating, control register and counter.
  // Index 0 is the transfer-count timer, index 1 the address timer.
  generate
    for (gi = 0; gi < 2; gi++) begin : g_timer
      localparam int PIN_IDX = (gi == 0) ? `TP_IN_PIN_A : `TP_IN_PIN_B;
      localparam int CLK_EXT = (gi == 0) ? `TP_IN_EXI2 : `TP_IN_EXI3;
      localparam int GATE_IRQ = (gi == 0) ? `TP_IN_IRQ0 : `TP_IN_IRQ1;
      localparam int GATE_EXT = (gi == 0) ? `TP_IN_EXI3 : `TP_IN_EXI2;
      logic source_pulse;
      logic gate_open;
      logic wr_hit;

      // Clock source: a pulse of the chosen rate or edge.
      always_comb begin
        unique case (clock_sel_e'(control[gi][`TP_BITS_CLOCK_SEL]))
          CLK_DIV12: source_pulse = div_tick;
          CLK_PIN: source_pulse = falling[PIN_IDX];
          CLK_SYSTEM: source_pulse = 1'b1;
          CLK_EXT_SEL: source_pulse = falling[CLK_EXT];
        endcase
      end

      // Gate: the interrupt events gate in their inverted sense.
      always_comb begin
        unique case (gate_sel_e'(control[gi][`TP_BITS_GATE_SEL]))
          GATE_NONE: gate_open = 1'b1;
          GATE_IRQ_LOW: gate_open = ~sync_level[GATE_IRQ];
          GATE_IRQ2_LOW: gate_open = ~sync_level[`TP_IN_IRQ2];
          GATE_EXT_SEL: gate_open = sync_level[GATE_EXT];
        endcase
      end

      assign count_tick[gi] = control[gi][`TP_BIT_RUN] & gate_open
                              & source_pulse;
      assign wr_hit = sfr_wr & page_hit[gi];

      // Control register. An overflow in the cycle of a software write
      // still sets the flag, so no event is lost to a clear.
      always_comb begin
        next_control[gi] = control[gi];
        if (wr_hit && sfr_addr == `TP_ADDR_CONTROL) begin
          next_control[gi] = sfr_wdata;
          next_control[gi][`TP_BIT_RESERVED] = 1'b0;
        end
        if (overflow[gi]) begin
          next_control[gi][`TP_BIT_FLAG] = 1'b1;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (srst) begin
          control[gi] <= `TP_CONTROL_RESET;
        end else begin
          control[gi] <= next_control[gi];
        end
      end

      timer_count_unit u_count (
        .clk_sys(clk_sys),
        .srst(srst),
        .count_tick(count_tick[gi]),
        .dma_enable(dma_enable),
        .dma_step(dma_step[gi]),
        .dma_reload(dma_reload),
        .wr_count_low(wr_hit && sfr_addr == `TP_ADDR_COUNT_LOW),
        .wr_count_high(wr_hit && sfr_addr == `TP_ADDR_COUNT_HIGH),
        .wr_reload_low(wr_hit && sfr_addr == `TP_ADDR_RELOAD_LOW),
        .wr_reload_high(wr_hit && sfr_addr == `TP_ADDR_RELOAD_HIGH),
        .wdata(sfr_wdata),
        .count(count[gi]),
        .reload(reload[gi]),
        .overflow(overflow[gi])
      );
    end
  endgenerate

  // The count flops feed the DMA engine directly as transfer count and
  // memory address; the base values stay in the reload bytes.
  assign transfer_count = count[0];
  assign memory_address = count[1];

  // Read mux: one page selects the timer, unmapped reads return zero.
  always_comb begin
    next_rdata = sfr_rdata;
    if (sfr_rd) begin
      next_rdata = 8'h00;
      for (int t = 0; t < 2; t++) begin
        if (page_hit[t]) begin
          unique case (sfr_addr)
            `TP_ADDR_CONTROL: next_rdata = control[t];
            `TP_ADDR_RELOAD_LOW: next_rdata = reload[t][7:0];
            `TP_ADDR_RELOAD_HIGH: next_rdata = reload[t][15:8];
            `TP_ADDR_COUNT_LOW: next_rdata = count[t][7:0];
            `TP_ADDR_COUNT_HIGH: next_rdata = count[t][15:8];
            default: next_rdata = 8'h00;
          endcase
        end
      end
    end
  end

  // Shared interrupt line. Software must keep the enables clear while a
  // DMA runs, since the line cannot tell DMA wraps from timer wraps.
  always_comb begin
    next_irq = (timer_a_control[`TP_BIT_FLAG]
                & timer_a_control[`TP_BIT_IRQ_ENABLE])
             | (timer_b_control[`TP_BIT_FLAG]
                & timer_b_control[`TP_BIT_IRQ_ENABLE]);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sfr_rdata <= `TP_BYTE_RESET;
      dma_irq <= 1'b0;
    end else begin
      sfr_rdata <= next_rdata;
      dma_irq <= next_irq;
    end
  end

  sequence s_div_quiet;
    !div_tick [*8];
  endsequence

  a_div_spacing: assert property (
    @(posedge clk_sys) disable iff (srst)
    div_tick |=> s_div_quiet)
    else $error("Divide-by-12 pulses too close together.");

  a_flag_a_set: assert property (
    @(posedge clk_sys) disable iff (srst)
    overflow[0] |=> timer_a_control[`TP_BIT_FLAG])
    else $error("First overflow flag not set after overflow.");

  a_flag_b_set: assert property (
    @(posedge clk_sys) disable iff (srst)
    overflow[1] |=> timer_b_control[`TP_BIT_FLAG])
    else $error("Second overflow flag not set after overflow.");

  a_flag_a_sticky: assert property (
    @(posedge clk_sys) disable iff (srst)
    (timer_a_control[`TP_BIT_FLAG] && !(sfr_wr && page_hit[0]
     && sfr_addr == `TP_ADDR_CONTROL)) |=> timer_a_control[`TP_BIT_FLAG])
    else $error("First overflow flag cleared without a write.");

  a_flag_b_sticky: assert property (
    @(posedge clk_sys) disable iff (srst)
    (timer_b_control[`TP_BIT_FLAG] && !(sfr_wr && page_hit[1]
     && sfr_addr == `TP_ADDR_CONTROL)) |=> timer_b_control[`TP_BIT_FLAG])
    else $error("Second overflow flag cleared without a write.");

  a_irq_raise: assert property (
    @(posedge clk_sys) disable iff (srst)
    (timer_a_control[`TP_BIT_FLAG] && timer_a_control[`TP_BIT_IRQ_ENABLE])
    |=> dma_irq)
    else $error("Interrupt not raised for enabled first flag.");

  a_irq_masked: assert property (
    @(posedge clk_sys) disable iff (srst)
    (!timer_a_control[`TP_BIT_IRQ_ENABLE]
     && !timer_b_control[`TP_BIT_IRQ_ENABLE]) |=> !dma_irq)
    else $error("Interrupt raised with both enables clear.");

  a_run_a_hold: assert property (
    @(posedge clk_sys) disable iff (srst)
    (!timer_a_control[`TP_BIT_RUN] && !dma_enable && !sfr_wr)
    |=> $stable(count[0]))
    else $error("First timer counted while stopped.");

  // The stop and gate checks look at the counter itself, so a broken
  // tick path inside the counter unit is caught as well.
  a_run_b_stop: assert property (
    @(posedge clk_sys) disable iff (srst)
    (!timer_b_control[`TP_BIT_RUN] && !dma_enable && !sfr_wr)
    |=> $stable(count[1]))
    else $error("Second timer counted while stopped.");

  a_gate_a_closed: assert property (
    @(posedge clk_sys) disable iff (srst)
    (timer_a_control[`TP_BITS_GATE_SEL] == GATE_IRQ_LOW
     && sync_level[`TP_IN_IRQ0] && !dma_enable && !sfr_wr)
    |=> $stable(count[0]))
    else $error("First timer counted with gate closed.");

  a_gate_b_closed: assert property (
    @(posedge clk_sys) disable iff (srst)
    (timer_b_control[`TP_BITS_GATE_SEL] == GATE_IRQ_LOW
     && sync_level[`TP_IN_IRQ1] && !dma_enable && !sfr_wr)
    |=> $stable(count[1]))
    else $error("Second timer counted with gate closed.");
endmodule : dma_companion_timer_pair
`default_nettype wire

/* test/event_source_model.sv */
// Behavioural source of the count pins, gate events and input selections.
`default_nettype none
module event_source_model (
  input wire logic clk_sys,
  output logic [6:0] lines
);
  timeunit 1ns;
  timeprecision 1ps;

  // Every line idles high, so the inverted event gates start closed.
  initial lines = 7'h7F;

  // A level changes just after a rising edge and then stays put.
  task automatic set_level(input int idx, input logic v);
    @(posedge clk_sys);
    lines[idx] <= v;
  endtask : set_level

  // Each half lasts three cycles, because a shorter pulse could slip
  // between the samples of the two-flop synchroniser.
  task automatic fall_pulse(input int idx);
    @(posedge clk_sys);
    lines[idx] <= 1'b0;
    repeat (3) @(posedge clk_sys);
    lines[idx] <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : fall_pulse
endmodule : event_source_model
`default_nettype wire

/* test/tb_top.sv */
// Bench for the timer pair: registers, counting, gating and DMA use.
`include "timer_pair_consts.svh"
`default_nettype none
module tb_top
  import timer_pair_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [3:0] page_a = `TP_PAGE_TIMER_A;
  localparam logic [3:0] page_b = `TP_PAGE_TIMER_B;
  localparam logic [7:0] a_ctl = `TP_ADDR_CONTROL;
  localparam logic [7:0] a_cnt = `TP_ADDR_COUNT_LOW;
  localparam logic [7:0] a_rld = `TP_ADDR_RELOAD_LOW;

  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] sfr_page = 4'h0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic dma_enable = 1'b0;
  logic dma_step_count = 1'b0;
  logic dma_step_address = 1'b0;
  logic dma_reload = 1'b0;
  logic [15:0] transfer_count;
  logic [15:0] memory_address;
  logic dma_irq;
  logic [6:0] ev;
  int num_errors = 0;
  int check_count = 0;

  // Free-running system clock of 4 ns.
  always #2 clk_sys = ~clk_sys;

  event_source_model partner (.clk_sys(clk_sys), .lines(ev));

  dma_companion_timer_pair dut (
    .clk_sys(clk_sys), .srst(srst), .sfr_page(sfr_page),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .timer_a_pin(ev[`TP_IN_PIN_A]), .timer_b_pin(ev[`TP_IN_PIN_B]),
    .ext_irq0_event(ev[`TP_IN_IRQ0]), .ext_irq1_event(ev[`TP_IN_IRQ1]),
    .ext_irq2_event(ev[`TP_IN_IRQ2]),
    .timer2_ext_input_sel(ev[`TP_IN_EXI2]),
    .timer3_ext_input_sel(ev[`TP_IN_EXI3]),
    .dma_enable(dma_enable), .dma_step_count(dma_step_count),
    .dma_step_address(dma_step_address), .dma_reload(dma_reload),
    .transfer_count(transfer_count), .memory_address(memory_address),
    .dma_irq(dma_irq)
  );

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bus cycles hold strobe, page, address and data until the taking edge.
  task automatic wr(input logic [3:0] pg, input logic [7:0] ad,
                    input logic [7:0] d);
    @(posedge clk_sys);
    sfr_wr <= 1'b1;
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_wdata <= d;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] pg, input logic [7:0] ad,
                    output logic [7:0] d);
    @(posedge clk_sys);
    sfr_rd <= 1'b1;
    sfr_page <= pg;
    sfr_addr <= ad;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask : rd

  // Writes a 16-bit value as low byte then high byte.
  task automatic load(input logic [3:0] pg, input logic [7:0] ad,
                      input logic [15:0] v);
    wr(pg, ad, v[7:0]);
    wr(pg, ad + 8'h01, v[15:8]);
  endtask : load

  function automatic logic [15:0] cnt(input logic [3:0] pg);
    return (pg == page_a) ? transfer_count : memory_address;
  endfunction : cnt

  // Control byte with the reserved bit always zero.
  function automatic logic [7:0] ctl(input logic [1:0] cs,
                                     input logic [1:0] gs);
    return {2'b00, cs, 1'b0, 1'b1, gs};
  endfunction : ctl

  task automatic wait_count(input logic [3:0] pg, input logic [15:0] v);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      #1;
      if (cnt(pg) === v) return;
    end
    check(cnt(pg), v);
    conclude;
  endtask : wait_count

  task automatic reg_access;
    logic [7:0] d;
    for (int p = 3; p <= 4; p++) begin
      for (int a = 8'hC8; a <= 8'hCD; a++) begin
        rd(p[3:0], a[7:0], d);
        check({8'h00, d}, 16'h0000);
        if (a >= 8'hCA) wr(p[3:0], a[7:0], {p[3:0], a[3:0]});
      end
      for (int a = 8'hCA; a <= 8'hCD; a++) begin
        rd(p[3:0], a[7:0], d);
        check({8'h00, d}, {8'h00, p[3:0], a[3:0]});
      end
      wr(p[3:0], a_ctl, 8'hBB);
      rd(p[3:0], a_ctl, d);
      check({8'h00, d}, 16'h00BB);
      repeat (2) @(posedge clk_sys);
      #1 check({15'h0000, dma_irq}, 16'h0001);
      wr(p[3:0], a_ctl, 8'h00);
    end
    wr(page_a, 8'hC9, 8'hAA);
    rd(page_a, 8'hC9, d);
    check({8'h00, d}, 16'h0000);
    wr(4'h5, a_cnt, 8'hAA);
    rd(page_b, a_cnt, d);
    check({8'h00, d}, 16'h004C);
  endtask : reg_access

  // Overflow reloads, sets a sticky flag and feeds the shared request.
  task automatic overflow(input logic [3:0] pg, input logic [15:0] rl);
    logic [7:0] d;
    logic [15:0] v;
    load(pg, a_rld, rl);
    load(pg, a_cnt, 16'hFFFD);
    wr(pg, a_ctl, ctl(CLK_SYSTEM, GATE_NONE));
    wait_count(pg, rl);
    rd(pg, a_ctl, d);
    check({8'h00, d}, 16'h00A4);
    wr(pg, a_ctl, 8'h80);
    repeat (2) @(posedge clk_sys);
    #1 v = cnt(pg);
    repeat (8) @(posedge clk_sys);
    #1 check(cnt(pg), v);
    check({15'h0000, dma_irq}, 16'h0000);
    rd(pg, a_ctl, d);
    check({8'h00, d}, 16'h0080);
    wr(pg, a_ctl, 8'h88);
    repeat (2) @(posedge clk_sys);
    #1 check({15'h0000, dma_irq}, 16'h0001);
    wr(pg, a_ctl, 8'h08);
    repeat (2) @(posedge clk_sys);
    #1 check({15'h0000, dma_irq}, 16'h0000);
    wr(pg, a_ctl, 8'h00);
  endtask : overflow

  task automatic div12(input logic [3:0] pg);
    int n;
    n = 0;
    load(pg, a_cnt, 16'h0000);
    wr(pg, a_ctl, ctl(CLK_DIV12, GATE_NONE));
    wait_count(pg, 16'h0001);
    while (n < 30 && cnt(pg) !== 16'h0002) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check(n[15:0], 16'h000C);
    wr(pg, a_ctl, 8'h00);
  endtask : div12

  task automatic ext_clock(input logic [3:0] pg, input logic [1:0] cs,
                           input int idx);
    load(pg, a_cnt, 16'h0000);
    wr(pg, a_ctl, ctl(cs, GATE_NONE));
    repeat (3) partner.fall_pulse(idx);
    repeat (4) @(posedge clk_sys);
    #1 check(cnt(pg), 16'h0003);
    wr(pg, a_ctl, 8'h00);
  endtask : ext_clock

  // The gate is closed first, then opened, then closed again.
  task automatic gate(input logic [3:0] pg, input logic [1:0] gs,
                      input int idx, input logic open);
    logic [15:0] v;
    partner.set_level(idx, !open);
    load(pg, a_cnt, 16'h0000);
    repeat (4) @(posedge clk_sys);
    wr(pg, a_ctl, ctl(CLK_SYSTEM, gs));
    repeat (10) @(posedge clk_sys);
    #1 check(cnt(pg), 16'h0000);
    partner.set_level(idx, open);
    repeat (10) @(posedge clk_sys);
    #1 check({15'h0000, cnt(pg) !== 16'h0000}, 16'h0001);
    partner.set_level(idx, !open);
    repeat (5) @(posedge clk_sys);
    #1 v = cnt(pg);
    repeat (8) @(posedge clk_sys);
    #1 check(cnt(pg), v);
    wr(pg, a_ctl, 8'h00);
    partner.set_level(idx, 1'b1);
  endtask : gate

  // Runs and interrupt enables stay clear while the DMA engine works.
  task automatic dma_use;
    wr(page_a, a_ctl, 8'h00);
    wr(page_b, a_ctl, 8'h00);
    load(page_a, a_rld, 16'h0100);
    load(page_b, a_rld, 16'h2000);
    @(posedge clk_sys);
    dma_enable <= 1'b1;
    dma_reload <= 1'b1;
    @(posedge clk_sys);
    dma_reload <= 1'b0;
    dma_step_count <= 1'b1;
    dma_step_address <= 1'b1;
    #1 check(transfer_count, 16'h0100);
    check(memory_address, 16'h2000);
    @(posedge clk_sys);
    dma_step_count <= 1'b0;
    dma_step_address <= 1'b0;
    @(posedge clk_sys);
    dma_step_count <= 1'b1;
    @(posedge clk_sys);
    dma_step_count <= 1'b0;
    @(posedge clk_sys);
    dma_enable <= 1'b0;
    #1 check(transfer_count, 16'h0102);
    check(memory_address, 16'h2001);
  endtask : dma_use

  // Main sequence; reset is held for two clock cycles.
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    reg_access();
    overflow(page_a, 16'h1234);
    overflow(page_b, 16'h5678);
    div12(page_a);
    div12(page_b);
    ext_clock(page_a, CLK_PIN, `TP_IN_PIN_A);
    ext_clock(page_b, CLK_PIN, `TP_IN_PIN_B);
    ext_clock(page_a, CLK_EXT_SEL, `TP_IN_EXI2);
    ext_clock(page_b, CLK_EXT_SEL, `TP_IN_EXI3);
    gate(page_a, GATE_IRQ_LOW, `TP_IN_IRQ0, 1'b0);
    gate(page_a, GATE_IRQ2_LOW, `TP_IN_IRQ2, 1'b0);
    gate(page_a, GATE_EXT_SEL, `TP_IN_EXI3, 1'b1);
    gate(page_b, GATE_IRQ_LOW, `TP_IN_IRQ1, 1'b0);
    gate(page_b, GATE_IRQ2_LOW, `TP_IN_IRQ2, 1'b0);
    gate(page_b, GATE_EXT_SEL, `TP_IN_EXI2, 1'b1);
    dma_use();
    conclude();
  end

  // A hung run is counted as a mismatch and closed here.
  initial begin
    repeat (60000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire
